// File: timer2_reload.v
// 16-bit reload timer with baud source, clock-out and toggle outputs,
// behind an APB slave. Assumes one 25 MHz clock and an APB master on it.
// Assumes the trigger and timer 2 pins are asynchronous to ref_clk, and
// that the timer 0/1 overflow pulses come from logic on ref_clk.
//
// Operation
// - Overflow reloads count from reload pair
// - Trigger-pin fall reloads and sets external flag
// - Up-only counts to ffff then reloads
// - Up/down follows direction pin level
// - Down count equal reload loads ffff
// - Up/down external flag toggles, no interrupt
// - Up-only: either flag raises interrupt
// - UART clock selects route overflow as baud
// - Baud mode counts shared timer ticks
// - Run, baud, capture, reload mode priority
// - Clock-out period set by reload value
// - Clock-out rollovers request no interrupt
// - Baud and clock-out run together
// - Timer 0/1 pins toggle on overflow
// - Timer 2 pin input or toggling output
// - UART1 selects live in mode register
// - UART0 selects live in control register
// - Over/underflow sets overflow flag except in baud or clock-out
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "timer2_consts.vh"
module timer2_reload (
  input  wire        ref_clk,          // 25 MHz clock
  input  wire        rst,              // Async reset, active high
  input  wire        psel,             // APB select
  input  wire        penable,          // APB access phase
  input  wire        pwrite,           // APB write
  input  wire [7:0]  paddr,            // APB byte address
  input  wire [31:0] pwdata,           // APB write data
  output reg  [31:0] prdata,           // APB read data
  output wire        pready,           // APB ready
  output wire        pslverr,          // APB error on unmapped address
  input  wire        ext_trigger_pin,  // Trigger / direction pin
  input  wire        t2_pin_in,        // Timer 2 pin level
  output wire        t2_pin_out,       // Timer 2 pin drive value
  output wire        t2_pin_oe_n,      // Timer 2 pin enable, low drives
  input  wire [1:0]  t01_overflow,     // Timer 0/1 overflow pulses
  output wire [1:0]  t01_pin_out,      // Timer 0/1 toggle values
  output wire [1:0]  t01_pin_oe_n,     // Timer 0/1 pin enables, low drives
  output wire        uart0_tx_baud,    // UART0 transmit bit-clock pulse
  output wire        uart0_rx_baud,    // UART0 receive bit-clock pulse
  output wire        uart1_tx_baud,    // UART1 transmit bit-clock pulse
  output wire        uart1_rx_baud,    // UART1 receive bit-clock pulse
  output wire        timer2_irq        // Interrupt request, level
);
  // ==========================================================
  // Registers
  reg [7:0]  ctrl_r;
  reg [7:0]  mode_r;
  reg [7:0]  pinctl_r;
  reg [15:0] reload_r;
  reg [15:0] count_r;
  reg        irq_en_r;
  reg [`TICK_DIV_W-1:0] div_r;
  reg        tick_r;
  reg        clkout_r;

  // Writable bits of the mode and pin control registers; the rest read back as 0
  localparam [7:0] mode_wr_mask = 8'h33;
  localparam [7:0] pin_wr_mask  = 8'h05;

  reg [7:0]  ctrl_nxt;
  reg [15:0] reload_nxt;
  reg [15:0] count_nxt;
  reg        ovf_evt;

  wire ext_level;
  wire ext_fall;
  wire t2_level;
  wire t2_fall;

  // ==========================================================
  // Pin synchronisers
  // Nothing reads either pin before its two flops
  pin_sync u_ext_sync (
    .clk   (ref_clk),
    .rst   (rst),
    .pin   (ext_trigger_pin),
    .level (ext_level),
    .fall  (ext_fall)
  );

  pin_sync u_t2_sync (
    .clk   (ref_clk),
    .rst   (rst),
    .pin   (t2_pin_in),
    .level (t2_level),
    .fall  (t2_fall)
  );

  // ==========================================================
  // APB decode
  // Byte registers sit in the low byte of each word
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_ctrl = (paddr == `OFS_CTRL);
  wire hit_mode = (paddr == `OFS_MODE);
  wire hit_pin  = (paddr == `OFS_PINCTL);
  wire hit_rl   = (paddr == `OFS_RELOAD_LO);
  wire hit_rh   = (paddr == `OFS_RELOAD_HI);
  wire hit_cl   = (paddr == `OFS_COUNT_LO);
  wire hit_ch   = (paddr == `OFS_COUNT_HI);
  wire hit_ie   = (paddr == `OFS_IRQ_EN);
  wire mapped   = hit_ctrl | hit_mode | hit_pin | hit_rl | hit_rh |
                  hit_cl | hit_ch | hit_ie;

  // Zero wait states keep the slave simple; every access ends in one cycle
  // Unmapped or misaligned addresses answer with an error and read 0
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ==========================================================
  // Mode decode
  // Priority: stopped, then baud, then capture, then reload
  wire run       = ctrl_r[`CTL_RUN];
  wire sel_rx0   = ctrl_r[`CTL_RX0_SEL];
  wire sel_tx0   = ctrl_r[`CTL_TX0_SEL];
  wire sel_rx1   = mode_r[`MOD_RX1_SEL];
  wire sel_tx1   = mode_r[`MOD_TX1_SEL];
  wire baud_mode = sel_rx0 | sel_tx0 | sel_rx1 | sel_tx1;
  wire cap_mode  = ~baud_mode & ctrl_r[`CTL_CAP_SEL];
  wire updown    = ~baud_mode & ~cap_mode & mode_r[`MOD_DOWN_EN];
  wire t2_oe     = mode_r[`MOD_T2_OE];
  wire ext_en    = ctrl_r[`CTL_EXT_EN];
  wire count_up  = ~updown | ext_level;

  // External count source only while the pin is an input
  wire pin_count = t2_fall & ~t2_oe;
  // Baud mode always steps on the tick, whatever the counter select says
  wire tick_src  = baud_mode | ~ctrl_r[`CTL_CNT_SEL];
  wire step      = run & (tick_src ? tick_r : pin_count);

  // Terminal counts for the two directions
  wire at_top    = (count_r == `COUNT_TOP);
  wire at_reload = (count_r == reload_r);

  // Direction pin doubles as trigger only outside up/down mode
  wire ext_evt   = run & ext_en & ext_fall & ~updown & ~baud_mode;

  // Rollovers feed baud and clock-out only, never the flag
  wire quiet     = baud_mode | t2_oe;

  // ==========================================================
  // Shared timer tick divider
  // Free-running, so the first step after run is set may lag by up to
  // three cycles; nothing depends on the tick phase
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r  <= {`TICK_DIV_W{1'b0}};
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_r + 1'b1;
      tick_r <= (div_r == `TICK_DIV - 1);
    end
  end

  // ==========================================================
  // Counter next state
  // Later assignments win: a trigger reload overrides a step, and a
  // software count write overrides both
  always @* begin
    count_nxt = count_r;
    ovf_evt   = 1'b0;
    if (step) begin
      if (cap_mode) begin
        count_nxt = count_r + 16'h0001;
        ovf_evt   = at_top;
      end else if (count_up) begin
        if (at_top) begin
          count_nxt = reload_r;
          ovf_evt   = 1'b1;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end else begin
        if (at_reload) begin
          count_nxt = `COUNT_TOP;
          ovf_evt   = 1'b1;
        end else begin
          count_nxt = count_r - 16'h0001;
        end
      end
    end
    if (ext_evt & ~cap_mode) begin
      count_nxt = reload_r;
    end
    if (wr & hit_cl) begin
      count_nxt = {count_nxt[15:8], pwdata[7:0]};
    end
    if (wr & hit_ch) begin
      count_nxt = {pwdata[7:0], count_nxt[7:0]};
    end
  end

  // ==========================================================
  // Reload pair: software writes, hardware capture in capture mode
  always @* begin
    reload_nxt = reload_r;
    if (wr & hit_rl) begin
      reload_nxt = {reload_r[15:8], pwdata[7:0]};
    end
    if (wr & hit_rh) begin
      reload_nxt = {pwdata[7:0], reload_r[7:0]};
    end
    // A capture on the same edge as a software write takes priority
    if (ext_evt & cap_mode) begin
      reload_nxt = count_r;
    end
  end

  // ==========================================================
  // Control register with flags; a hardware set beats a software clear
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr & hit_ctrl) begin
      ctrl_nxt = pwdata[7:0];
    end
    if (ovf_evt & ~quiet) begin
      ctrl_nxt[`CTL_OVF] = 1'b1;
    end
    // As a 17th count bit the external flag toggles even over a write
    if (ovf_evt & updown) begin
      ctrl_nxt[`CTL_EXF] = ~ctrl_r[`CTL_EXF];
    end else if (ext_evt) begin
      ctrl_nxt[`CTL_EXF] = 1'b1;
    end
  end

  // ==========================================================
  // State update
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r      <= `RST_BYTE;
      mode_r      <= `RST_BYTE;
      pinctl_r    <= `RST_BYTE;
      reload_r    <= `RST_WORD;
      count_r     <= `RST_WORD;
      irq_en_r    <= 1'b0;
      clkout_r    <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      reload_r    <= reload_nxt;
      count_r     <= count_nxt;
      // Writes keep only the implemented bits
      if (wr & hit_mode) begin
        mode_r <= pwdata[7:0] & mode_wr_mask;
      end
      if (wr & hit_pin) begin
        pinctl_r <= pwdata[7:0] & pin_wr_mask;
      end
      if (wr & hit_ie) begin
        irq_en_r <= pwdata[0];
      end
      // Half period is one full reload cycle, giving tick/(2*(65536-reload))
      if (ovf_evt & t2_oe) begin
        clkout_r <= ~clkout_r;
      end
    end
  end

  // ==========================================================
  // Timer 0/1 toggle outputs
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_t01
      wire oe_bit = pinctl_r[gi * 2];
      // The toggle keeps its level while the pin is an input
      reg  tog_r;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          tog_r <= 1'b0;
        end else if (oe_bit & t01_overflow[gi]) begin
          tog_r <= ~tog_r;
        end
      end
      assign t01_pin_out[gi]  = tog_r;
      assign t01_pin_oe_n[gi] = ~oe_bit;
    end
  endgenerate

  // ==========================================================
  // Outputs
  // Pin direction follows the enable bit alone, in every mode
  assign t2_pin_out  = clkout_r;
  assign t2_pin_oe_n = ~t2_oe;

  // ==========================================================
  // Baud pulses, one flop per UART direction
  // Pulses stay valid while clock-out runs; the UART divides by 8 itself.
  // Each select gates its own flop, so a select rewritten just after an
  // overflow cannot clip a pulse already under way.
  wire [3:0] baud_sel = {sel_rx1, sel_tx1, sel_rx0, sel_tx0};
  wire [3:0] baud_q;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_baud
      reg pulse_r;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pulse_r <= 1'b0;
        end else begin
          pulse_r <= ovf_evt & baud_mode & baud_sel[gi];
        end
      end
      assign baud_q[gi] = pulse_r;
    end
  endgenerate

  assign uart0_tx_baud = baud_q[0];
  assign uart0_rx_baud = baud_q[1];
  assign uart1_tx_baud = baud_q[2];
  assign uart1_rx_baud = baud_q[3];

  // ==========================================================
  // Interrupt request
  // Level output: it stays high until software clears the flags.
  // The external flag only requests service outside up/down counting.
  assign timer2_irq = irq_en_r & (ctrl_r[`CTL_OVF] |
                      (ctrl_r[`CTL_EXF] & ~updown));

  // ==========================================================
  // Read mux
  // Halves are read one at a time with no latch; software reading a
  // running count must allow for a carry between the two reads
  always @* begin
    prdata = 32'h0000_0000;
    if (acc & ~pwrite) begin
      case (paddr)
        `OFS_CTRL:      prdata = {24'h000000, ctrl_r};
        `OFS_MODE:      prdata = {24'h000000, mode_r};
        `OFS_PINCTL:    prdata = {24'h000000, pinctl_r};
        `OFS_RELOAD_LO: prdata = {24'h000000, reload_r[7:0]};
        `OFS_RELOAD_HI: prdata = {24'h000000, reload_r[15:8]};
        `OFS_COUNT_LO:  prdata = {24'h000000, count_r[7:0]};
        `OFS_COUNT_HI:  prdata = {24'h000000, count_r[15:8]};
        `OFS_IRQ_EN:    prdata = {31'h00000000, irq_en_r};
        default:        prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// File: timer2_consts.vh
// Constants for the 16-bit reload timer: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the timer design files.
`ifndef TIMER2_CONSTS_VH
`define TIMER2_CONSTS_VH

// ==========================================================
// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_MODE       8'h04
`define OFS_PINCTL     8'h08
`define OFS_RELOAD_LO  8'h0c
`define OFS_RELOAD_HI  8'h10
`define OFS_COUNT_LO   8'h14
`define OFS_COUNT_HI   8'h18
`define OFS_IRQ_EN     8'h1c

// ==========================================================
// Control register fields
`define CTL_OVF        7
`define CTL_EXF        6
`define CTL_RX0_SEL    5
`define CTL_TX0_SEL    4
`define CTL_EXT_EN     3
`define CTL_RUN        2
`define CTL_CNT_SEL    1
`define CTL_CAP_SEL    0

// Mode register fields
`define MOD_RX1_SEL    5
`define MOD_TX1_SEL    4
`define MOD_T2_OE      1
`define MOD_DOWN_EN    0

// Pin output control fields
`define PIN_T1_OE      2
`define PIN_T0_OE      0

// ==========================================================
// Reset values and terminal count
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define COUNT_TOP      16'hffff

// ==========================================================
// Timing: the shared timer tick is the 25 MHz clock divided down
`define TICK_DIV       4
`define TICK_DIV_W     2

`endif

// File: pin_sync.v
// Two-flop synchroniser for one pin with a falling edge detector.
// Assumes the pin is asynchronous to clk; edge logic reads the second
// flop and a third one only.
`timescale 1ns/1ns
module pin_sync (
  input  wire clk,    // System clock
  input  wire rst,    // Async reset, active high
  input  wire pin,    // Raw pin level
  output wire level,  // Synchronised level
  output wire fall    // One-cycle pulse on a 1-to-0 change
);
  reg meta_r;
  reg sync_r;
  reg prev_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign fall  = prev_r & ~sync_r;
endmodule

// File: timer2_reload_monitor.sv
// Concurrent checks for the reload timer, seen from its top-level ports.
// Assumes one ref_clk domain and an async active-high rst.
`timescale 1ns/1ns
module timer2_reload_monitor (
  input wire logic        ref_clk,       // Clock
  input wire logic        rst,           // Reset, active high
  input wire logic        psel,          // APB select
  input wire logic        penable,       // APB access phase
  input wire logic        pwrite,        // APB write
  input wire logic [7:0]  paddr,         // APB address
  input wire logic [31:0] pwdata,        // APB write data
  input wire logic [31:0] prdata,        // APB read data
  input wire logic        pready,        // APB ready
  input wire logic        pslverr,       // APB error
  input wire logic        t2_pin_out,    // Clock-out value
  input wire logic        t2_pin_oe_n,   // Clock-out enable, low drives
  input wire logic [1:0]  t01_overflow,  // Timer 0/1 overflow pulses
  input wire logic [1:0]  t01_pin_out,   // Timer 0/1 toggle values
  input wire logic [1:0]  t01_pin_oe_n,  // Timer 0/1 enables, low drives
  input wire logic        uart0_tx_baud  // UART0 transmit bit clock
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;

  // ==========================================================
  // Bus side
  chk_ready_high: assert property (acc |-> pready) else $error("pready low in access");
  chk_unmapped_err: assert property (acc && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_idle_rdata: assert property (!acc |-> prdata == 32'h0) else $error("prdata not idle");

  // ==========================================================
  // Pins and baud
  chk_t2_oe_write: assert property (acc && pwrite && paddr == 8'h04 |=>
    t2_pin_oe_n == !$past(pwdata[1])) else $error("t2 enable not from mode write");
  chk_t01_oe_write: assert property (acc && pwrite && paddr == 8'h08 |=>
    t01_pin_oe_n == ~{$past(pwdata[2]), $past(pwdata[0])}) else $error("t01 enables wrong");
  chk_t0_hold_quiet: assert property (!t01_overflow[0] |=> $stable(t01_pin_out[0]))
    else $error("t0 output moved without overflow");
  chk_t0_toggle_ovf: assert property (t01_overflow[0] && !t01_pin_oe_n[0] |=>
    t01_pin_out[0] != $past(t01_pin_out[0])) else $error("t0 output missed toggle");
  chk_baud_one_cycle: assert property (uart0_tx_baud |=> !uart0_tx_baud [*3])
    else $error("baud pulse too long or too close");
  chk_clkout_gap: assert property ($changed(t2_pin_out) |=> $stable(t2_pin_out) [*3])
    else $error("clock-out toggles faster than a tick");

  cover property (uart0_tx_baud);
  cover property (acc && pslverr);
  cover property ($changed(t2_pin_out));
endmodule

bind timer2_reload timer2_reload_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .t2_pin_out(t2_pin_out), .t2_pin_oe_n(t2_pin_oe_n),
  .t01_overflow(t01_overflow), .t01_pin_out(t01_pin_out), .t01_pin_oe_n(t01_pin_oe_n),
  .uart0_tx_baud(uart0_tx_baud));

// File: timer2_reload_test.sv
// Self-checking bench for the reload timer: APB tasks and directed tests.
// Assumes the design header and the bound monitor are compiled with it.
`timescale 1ns/1ns
module timer2_reload_test;
  logic        ref_clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ext_trigger_pin = 1;
  logic        t2_pin_in = 1;
  logic [1:0]  t01_overflow = 2'h0;
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata;
  wire         pready, pslverr, t2_pin_out, t2_pin_oe_n, timer2_irq;
  wire  [1:0]  t01_pin_out, t01_pin_oe_n;
  wire  [3:0]  baud;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] n [4];
  time         t0;

  always #20 ref_clk = ~ref_clk;

  timer2_reload i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trigger_pin(ext_trigger_pin), .t2_pin_in(t2_pin_in),
    .t2_pin_out(t2_pin_out), .t2_pin_oe_n(t2_pin_oe_n), .t01_overflow(t01_overflow),
    .t01_pin_out(t01_pin_out), .t01_pin_oe_n(t01_pin_oe_n), .uart0_tx_baud(baud[0]),
    .uart0_rx_baud(baud[1]), .uart1_tx_baud(baud[2]), .uart1_rx_baud(baud[3]),
    .timer2_irq(timer2_irq));

  // ==========================================================
  // Tasks
  task end_sim;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits on pready at each access edge; only the bench timeout ends a stall
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, exp});
  endtask

  task pause(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  // A hang counts as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    pause(10);
    rst <= 0;
    rdc(8'h00, 8'h00);
    rdc(8'h04, 8'h00);
    rdc(8'h08, 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    wr(8'h04, 8'hff);
    rdc(8'h04, 8'h33);
    wr(8'h08, 8'hff);
    rdc(8'h08, 8'h05);
    chk(32'(t01_pin_oe_n), 32'h0);
    t01_overflow <= 2'h3;
    pause(1);
    t01_overflow <= 2'h0;
    pause(1);
    chk(32'(t01_pin_out), 32'h3);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h00);
    // Up-only reload from 1234 after rolling over
    wr(8'h1c, 8'h01);
    wr(8'h0c, 8'h34);
    wr(8'h10, 8'h12);
    wr(8'h14, 8'hfe);
    wr(8'h18, 8'hff);
    wr(8'h00, 8'h04);
    pause(20);
    rdc(8'h18, 8'h12);
    rdc(8'h00, 8'h84);
    chk(32'(timer2_irq), 32'h1);
    wr(8'h00, 8'h00);
    pause(1);
    chk(32'(timer2_irq), 32'h0);
    // Trigger pin fall reloads mid-count
    wr(8'h14, 8'h78);
    wr(8'h18, 8'h56);
    wr(8'h00, 8'h0c);
    ext_trigger_pin <= 0;
    pause(10);
    rdc(8'h18, 8'h12);
    rdc(8'h00, 8'h4c);
    chk(32'(timer2_irq), 32'h1);
    ext_trigger_pin <= 1;
    wr(8'h00, 8'h00);
    // Down count hits the reload value, then turns round
    wr(8'h04, 8'h01);
    wr(8'h14, 8'h36);
    ext_trigger_pin <= 0;
    wr(8'h00, 8'h04);
    pause(20);
    rdc(8'h18, 8'hff);
    rdc(8'h00, 8'hc4);
    wr(8'h00, 8'h44);
    pause(1);
    chk(32'(timer2_irq), 32'h0);
    ext_trigger_pin <= 1;
    pause(80);
    rdc(8'h18, 8'h12);
    rdc(8'h00, 8'h84);
    wr(8'h00, 8'h00);
    // Baud on all four selects with clock-out running alongside
    wr(8'h0c, 8'hfe);
    wr(8'h10, 8'hff);
    wr(8'h14, 8'hfe);
    wr(8'h18, 8'hff);
    wr(8'h04, 8'h33);
    wr(8'h00, 8'h34);
    pause(10);
    chk(32'(t2_pin_oe_n), 32'h0);
    foreach (n[i]) n[i] = 0;
    repeat (80) begin
      @(posedge ref_clk);
      foreach (n[i]) n[i] += baud[i];
    end
    foreach (n[i]) chk(32'(n[i]), 32'd10);
    @(t2_pin_out);
    t0 = $time;
    @(t2_pin_out);
    chk(32'($time - t0), 32'd320);
    rdc(8'h00, 8'h34);
    chk(32'(timer2_irq), 32'h0);
    // Clock-out alone: rollovers toggle the pin but leave the flag clear
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h04);
    pause(40);
    rdc(8'h00, 8'h04);
    chk(32'(timer2_irq), 32'h0);
    // Counter mode: three pin falls give three steps, ticks ignored
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h06);
    repeat (3) begin
      t2_pin_in <= 0;
      pause(4);
      t2_pin_in <= 1;
      pause(4);
    end
    rdc(8'h14, 8'h03);
    // Stopped: a further pin fall leaves the count alone
    wr(8'h00, 8'h02);
    t2_pin_in <= 0;
    pause(6);
    t2_pin_in <= 1;
    rdc(8'h14, 8'h03);
    end_sim();
  end
endmodule
